// ==== hdl/i2sap_defines.svh ====
// Constants of the I2C slave address phase block.
// Assumes a 20 MHz system clock; included by the slave module.
`ifndef I2SAP_DEFINES_SVH
`define I2SAP_DEFINES_SVH

// =============================================================
// Timing
`define I2SAP_CLK_NS      50
`define I2SAP_STRETCH_NS  1000
`define I2SAP_STRETCH_CYC \
    ((`I2SAP_STRETCH_NS + `I2SAP_CLK_NS - 1) / `I2SAP_CLK_NS)

// =============================================================
// Bit positions and counts
`define I2SAP_DIR_BIT     0
`define I2SAP_ADDR_BITS   8
`define I2SAP_ACK_BIT     9

// =============================================================
// Reset values of the event enables
`define I2SAP_RX_EN_RST   1'b1
`define I2SAP_TX_EN_RST   1'b0
`define I2SAP_STOP_EN_RST 1'b0

`endif

// ==== hdl/i2sap_pkg.sv ====
// Types of the I2C slave address phase block.
// Assumes nothing of its surroundings.
package i2sap_pkg;

    typedef enum logic [2:0]
    {
        I2SAP_IDLE    = 3'h0,
        I2SAP_ADDR    = 3'h1,
        I2SAP_CHECK   = 3'h3,
        I2SAP_STRETCH = 3'h2,
        I2SAP_ACK9    = 3'h6,
        I2SAP_DATA    = 3'h7,
        I2SAP_IGNORE  = 3'h5
    } i2sap_state_t;

    typedef enum logic [1:0]
    {
        I2SAP_SEL_NONE = 2'h0,
        I2SAP_SEL_RX   = 2'h1,
        I2SAP_SEL_TX   = 2'h2
    } i2sap_sel_t;

endpackage

// ==== hdl/i2sap_slave.sv ====
// Address phase of an I2C slave: receive, match, acknowledge, stretch.
// Assumes one master; SCL and SDA are asynchronous pins, open drain.
`include "i2sap_defines.svh"

module i2sap_slave
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [6:0] own_addr,
    input  wire logic [7:0] tx_first_byte,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            rx_event,
    output logic            rx_event_en,
    output logic            tx_event_en,
    output logic            stop_event_en,
    output logic [7:0]      serial_receive_buffer,
    output logic [7:0]      tx_buffer,
    output logic [1:0]      buffer_sel,
    output logic            direction,
    output logic            ack_armed,
    output logic [7:0]      byte_count,
    output logic            transfer_done
);

    // =========================================================
    // Address match check
    function automatic i2sap_pkg::i2sap_sel_t address_match_check
    (
        input logic [6:0] addr,
        input logic       rw,
        input logic [6:0] own
    );
        if (addr != own)
            return i2sap_pkg::I2SAP_SEL_NONE;
        else if (rw)
            return i2sap_pkg::I2SAP_SEL_TX;
        else
            return i2sap_pkg::I2SAP_SEL_RX;
    endfunction

    // =========================================================
    // Pin synchronisers and edge detection
    logic                  scl_meta;
    logic                  scl_s;
    logic                  scl_d;
    logic                  sda_meta;
    logic                  sda_s;
    logic                  sda_d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    i2sap_pkg::i2sap_state_t state;
    i2sap_pkg::i2sap_sel_t   sel;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift_reg;
    logic [4:0]            stretch_cnt;
    logic                  match;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            scl_d    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_d    <= 1'b1;
        end
        else
        begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            scl_d    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_d    <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    // SDA edges only count while SCL stays high on both samples
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    assign sel       = address_match_check(serial_receive_buffer[7:1],
                           serial_receive_buffer[`I2SAP_DIR_BIT], own_addr);
    assign match     = (sel != i2sap_pkg::I2SAP_SEL_NONE);

    // =========================================================
    // Bit counter and shifter
    always_ff @(posedge clk)
    begin
        if (reset || start_det)
            bit_cnt <= 4'h0;
        else if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
        else if (scl_fall && bit_cnt == 4'(`I2SAP_ACK_BIT))
            bit_cnt <= 4'h0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            shift_reg <= 8'h00;
        else if (scl_rise)
            shift_reg <= {shift_reg[6:0], sda_s};
    end

    // =========================================================
    // Sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
            state <= i2sap_pkg::I2SAP_IDLE;
        else if (start_det)
            state <= i2sap_pkg::I2SAP_ADDR;
        else if (stop_det)
            state <= i2sap_pkg::I2SAP_IDLE;
        else
        begin
            unique case (state)
                i2sap_pkg::I2SAP_IDLE:
                    state <= i2sap_pkg::I2SAP_IDLE;
                i2sap_pkg::I2SAP_ADDR:
                    if (scl_fall && bit_cnt == 4'(`I2SAP_ADDR_BITS))
                        state <= i2sap_pkg::I2SAP_CHECK;
                i2sap_pkg::I2SAP_CHECK:
                    state <= match ? i2sap_pkg::I2SAP_STRETCH
                                   : i2sap_pkg::I2SAP_IGNORE;
                i2sap_pkg::I2SAP_STRETCH:
                    if (stretch_cnt == 5'h00)
                        state <= i2sap_pkg::I2SAP_ACK9;
                i2sap_pkg::I2SAP_ACK9:
                    if (scl_fall && bit_cnt == 4'(`I2SAP_ACK_BIT))
                        state <= i2sap_pkg::I2SAP_DATA;
                i2sap_pkg::I2SAP_DATA:
                    state <= i2sap_pkg::I2SAP_DATA;
                i2sap_pkg::I2SAP_IGNORE:
                    state <= i2sap_pkg::I2SAP_IGNORE;
                default:
                    state <= i2sap_pkg::I2SAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rx_event <= 1'b0;
        else
            rx_event <= rx_event_en && state == i2sap_pkg::I2SAP_ADDR
                        && scl_fall && bit_cnt == 4'(`I2SAP_ADDR_BITS);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            serial_receive_buffer <= 8'h00;
        else if (state == i2sap_pkg::I2SAP_ADDR && scl_fall
                 && bit_cnt == 4'(`I2SAP_ADDR_BITS))
            serial_receive_buffer <= shift_reg;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            buffer_sel <= i2sap_pkg::I2SAP_SEL_NONE;
            direction  <= 1'b0;
        end
        else if (state == i2sap_pkg::I2SAP_CHECK)
        begin
            buffer_sel <= sel;
            direction  <= serial_receive_buffer[`I2SAP_DIR_BIT];
        end
    end

    // =========================================================
    // Acknowledge and clock hold
    // ACK or NACK
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else if (state == i2sap_pkg::I2SAP_CHECK)
            sda_oe <= match;
        else if (scl_fall || stop_det || start_det)
            sda_oe <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_out     <= 1'b0;
            scl_oe      <= 1'b0;
            stretch_cnt <= 5'h00;
        end
        else if (state == i2sap_pkg::I2SAP_CHECK)
        begin
            scl_oe      <= match;
            stretch_cnt <= 5'(`I2SAP_STRETCH_CYC - 1);
        end
        else if (state == i2sap_pkg::I2SAP_STRETCH)
        begin
            if (stretch_cnt == 5'h00)
                scl_oe <= 1'b0;
            else
                stretch_cnt <= stretch_cnt - 5'h01;
        end
        else
            scl_oe <= 1'b0;
    end

    // =========================================================
    // Event enables, preparation, count and status
    // enables switched and restored
    always_ff @(posedge clk)
    begin
        if (reset || (stop_det && stop_event_en))
        begin
            rx_event_en   <= `I2SAP_RX_EN_RST;
            tx_event_en   <= `I2SAP_TX_EN_RST;
            stop_event_en <= `I2SAP_STOP_EN_RST;
        end
        else if (state == i2sap_pkg::I2SAP_CHECK && match)
        begin
            rx_event_en   <= 1'b0;
            tx_event_en   <= 1'b1;
            stop_event_en <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset || stop_det)
            ack_armed <= 1'b0;
        else if (state == i2sap_pkg::I2SAP_CHECK && match)
            ack_armed <= ~serial_receive_buffer[`I2SAP_DIR_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            tx_buffer <= 8'h00;
        else if (state == i2sap_pkg::I2SAP_CHECK
                 && sel == i2sap_pkg::I2SAP_SEL_TX)
            tx_buffer <= tx_first_byte;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            byte_count    <= 8'h00;
            transfer_done <= 1'b0;
        end
        else if (stop_det && stop_event_en)
            transfer_done <= 1'b1;
        else if (state == i2sap_pkg::I2SAP_CHECK && match)
        begin
            byte_count    <= 8'h00;
            transfer_done <= 1'b0;
        end
        else if (state == i2sap_pkg::I2SAP_DATA && scl_fall
                 && bit_cnt == 4'(`I2SAP_ACK_BIT))
            byte_count <= byte_count + 8'h01;
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic chk_match;
    assign chk_match = state == i2sap_pkg::I2SAP_CHECK && match && !stop_det;

    AST_RX_EVENT: assert property
        (rx_event_en && state == i2sap_pkg::I2SAP_ADDR && scl_fall
         && bit_cnt == 4'(`I2SAP_ADDR_BITS) |=> rx_event)
        else $error("receive event missing at eighth fall");
    AST_READ_FIRST: assert property
        (rx_event && !start_det && !stop_det
         |-> state == i2sap_pkg::I2SAP_CHECK
         && serial_receive_buffer == $past(shift_reg))
        else $error("address checked before buffer read");
    AST_ACK_LOW: assert property
        (chk_match |=> sda_oe && !sda_out)
        else $error("no ACK on address match");
    AST_HOLD: assert property
        (chk_match && !start_det |=> scl_oe [*8])
        else $error("clock hold too short");
    AST_ENABLES: assert property
        (chk_match |=> !rx_event_en && tx_event_en && stop_event_en)
        else $error("event enables not switched");
    AST_CLEAR: assert property
        (chk_match |=> byte_count == 8'h00 && !transfer_done)
        else $error("count or status not cleared");
    AST_ARM_ACK: assert property
        (chk_match && !serial_receive_buffer[0] |=> ack_armed)
        else $error("ACK not armed for write");
    AST_LOAD_TX: assert property
        (chk_match && serial_receive_buffer[0]
         |=> tx_buffer == $past(tx_first_byte) && direction)
        else $error("first byte not loaded");
    AST_NACK: assert property
        (state == i2sap_pkg::I2SAP_CHECK && !match |=> !sda_oe && !scl_oe)
        else $error("NACK case drives a pin");
    AST_RELEASE: assert property
        (state == i2sap_pkg::I2SAP_STRETCH && stretch_cnt == 5'h00
         |=> !scl_oe)
        else $error("clock hold not released");
    AST_STOP: assert property
        (stop_det && stop_event_en
         |=> transfer_done && rx_event_en && !tx_event_en && !stop_event_en)
        else $error("stop did not restore settings");

    COV_WRITE: cover property (chk_match && !serial_receive_buffer[0]);
    COV_READ: cover property (chk_match && serial_receive_buffer[0]);
    COV_NOMATCH: cover property (state == i2sap_pkg::I2SAP_CHECK && !match);
    COV_DONE: cover property ($rose(transfer_done));

endmodule

// ==== verification/i2sap_master.sv ====
// Bus master model: start, address byte, one data byte on ACK, stop.
// Assumes the bench resolves both open-drain wires with pull-ups.
module i2sap_master
(
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Bus idle
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ==========================================
    // One bit; low phase 6 cycles, high 2
    // High phase waits out a stretch, bounded
    task automatic pulse(input logic b, output logic seen);
        int k;
        wait_clk(3);
        sda_o = b;
        wait_clk(3);
        scl_o = 1'b1;
        k = 0;
        while (scl !== 1'b1 && k < 200)
        begin
            wait_clk(1);
            k++;
        end
        wait_clk(2);
        seen = sda;
        scl_o = 1'b0;
    endtask

    // ==========================================
    // Address byte MSB first, then released SDA
    task automatic xfer(input logic [7:0] b, output logic ack);
        logic       s;
        logic [7:0] d;
        sda_o = 1'b0;
        wait_clk(4);
        scl_o = 1'b0;
        for (int i = 7; i >= 0; i--)
            pulse(b[i], s);
        pulse(1'b1, s);
        ack = ~s;
        // One data byte after an ACK, so the byte count moves
        if (ack)
        begin
            d = 8'($urandom);
            for (int i = 7; i >= 0; i--)
                pulse(d[i], s);
            pulse(1'b1, s);
        end
        wait_clk(3);
        sda_o = 1'b0;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(4);
        sda_o = 1'b1;
        wait_clk(8);
    endtask
endmodule

// ==== verification/i2c_slave_address_phase_bench.sv ====
// Bench of the slave address phase: master model plus checks.
// Assumes 20 MHz clock; inputs change at the falling edge.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("FAIL %0t %h %h", $time, a, b); end end

module i2c_slave_address_phase_bench;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed
    {
        logic [7:0] rxb;
        logic       hit;
        logic       rd;
        logic [7:0] txb;
    } i2sap_exp_t;

    logic clk, reset, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
    logic rx_event, rx_event_en, tx_event_en, stop_event_en;
    logic direction, ack_armed, transfer_done, m_scl, m_sda;
    logic [6:0] own_addr, addr;
    logic [7:0] tx_first_byte, serial_receive_buffer, tx_buffer;
    logic [7:0] byte_count, n;
    logic [1:0] buffer_sel, sel;
    logic rd, hit, ack, done_exp;
    int n_errors, compares;
    i2sap_exp_t q[$];
    i2sap_exp_t e;

    // ==========================================
    // Wires with pull-ups
    assign scl_in = m_scl & (~scl_oe | scl_out);
    assign sda_in = m_sda & (~sda_oe | sda_out);

    i2sap_slave uut
    (
        .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
        .own_addr(own_addr), .tx_first_byte(tx_first_byte),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .rx_event(rx_event), .rx_event_en(rx_event_en),
        .tx_event_en(tx_event_en), .stop_event_en(stop_event_en),
        .serial_receive_buffer(serial_receive_buffer),
        .tx_buffer(tx_buffer), .buffer_sel(buffer_sel),
        .direction(direction), .ack_armed(ack_armed),
        .byte_count(byte_count), .transfer_done(transfer_done)
    );

    i2sap_master m
    (
        .clk(clk), .scl(scl_in), .sda(sda_in),
        .scl_o(m_scl), .sda_o(m_sda)
    );

    always #25 clk = ~clk;

    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================
    // Watcher: one note per receive event
    always @(negedge clk)
    begin
        if (rx_event === 1'b1)
        begin
            if (q.size() == 0)
                `CHK(1'b0, 1'b1)
            else
            begin
                e = q.pop_front();
                `CHK(serial_receive_buffer, e.rxb)
                sel = !e.hit ? i2sap_pkg::I2SAP_SEL_NONE :
                      e.rd ? i2sap_pkg::I2SAP_SEL_TX :
                      i2sap_pkg::I2SAP_SEL_RX;
                @(negedge clk);
                `CHK({sda_oe, rx_event}, {e.hit, 1'b0})
                `CHK(rx_event_en, ~e.hit)
                `CHK({tx_event_en, stop_event_en}, {2{e.hit}})
                `CHK(buffer_sel, sel)
                `CHK(ack_armed, e.hit & ~e.rd)
                if (e.hit)
                begin
                    `CHK({byte_count, transfer_done}, 9'h000)
                    `CHK(direction, e.rd)
                end
                if (e.hit && e.rd)
                    `CHK(tx_buffer, e.txb)
                n = 8'h00;
                while (scl_oe === 1'b1 && n < 8'h3C)
                begin
                    n++;
                    @(negedge clk);
                end
                `CHK(n, e.hit ? 8'h14 : 8'h00)
            end
        end
    end

    // ==========================================
    // Watchdog, far beyond six transfers
    initial
    begin
        repeat (20000) @(negedge clk);
        n_errors++;
        results();
    end

    // ==========================================
    // Main sequence: misses, reads and writes
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        own_addr = 7'h00;
        tx_first_byte = 8'h00;
        done_exp = 1'b0;
        n_errors = 0;
        compares = 0;
        void'($urandom(32'h76FF4C42));
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 6; i++)
        begin
            rd = i[0];
            hit = (i % 3) != 0;
            own_addr = 7'($urandom);
            tx_first_byte = 8'($urandom);
            addr = own_addr;
            if (!hit)
                addr = own_addr ^ (7'h01 << ($urandom % 7));
            q.push_back({addr, rd, hit, rd, tx_first_byte});
            m.xfer({addr, rd}, ack);
            `CHK(ack, hit)
            if (hit)
                done_exp = 1'b1;
            `CHK(transfer_done, done_exp)
            `CHK(byte_count, {7'h00, done_exp})
            `CHK({rx_event_en, tx_event_en, stop_event_en}, 3'h4)
            `CHK(ack_armed, 1'b0)
        end
        `CHK(q.size() == 0, 1'b1)
        results();
    end
endmodule
